// file: design/gate_cfg_map.svh
// Constants for the host-side controller of a triple configurable gate.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef GATE_CFG_MAP_SVH
`define GATE_CFG_MAP_SVH

`define GATE_CELLS 3
// Function codes driven on the command port
`define FN_BUFFER 3'h0
`define FN_INVERT 3'h1
`define FN_MUX 3'h2
`define FN_AND 3'h3
`define FN_NAND 3'h4
`define FN_XOR 3'h5
`define FN_XNOR 3'h6
`define FN_MUX_INV 3'h7
// Pin drive while in reset: disabled, all ties low
`define PINS_OFF 5'h10

`endif

// file: design/gate_cfg_pkg.sv
// Types for the host-side controller of the configurable gate.
// Assumes the map header supplies numeric constants.
package gate_cfg_pkg;
    // Pin drive of one cell
    typedef struct packed {
        logic oe_low;
        logic in_a;
        logic in_b;
        logic in_sel;
        logic in_invert;
    } cell_pins_t;

    // Request for one cell: function and two operands
    typedef struct packed {
        logic enable;
        logic [2:0] func;
        logic op1;
        logic op2;
    } cell_cmd_t;
endpackage

// file: design/gate_cfg_host.sv
// Host controller: turns per-cell function requests into tie levels on the
// pins of a triple configurable gate and samples the returned outputs.
// Assumes gate outputs arrive asynchronously and are pulled when floating.
// Assumes requests come from logic on this clock and need no synchroniser.
`timescale 1ns/1ps
`default_nettype none
`include "gate_cfg_map.svh"

module gate_cfg_host #(
    parameter int CELLS = `GATE_CELLS
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire gate_cfg_pkg::cell_cmd_t cmd_in [CELLS],
    input wire logic [CELLS-1:0] gate_out_in,
    output gate_cfg_pkg::cell_pins_t pins_out [CELLS],
    output logic [CELLS-1:0] result_out,
    output logic [CELLS-1:0] expect_out
);

    // ****************************************
    // Tie-pattern encoder
    // ****************************************
    // Only two operands reach a cell, so the mux codes cannot carry a separate
    // select; the select is steered from the operands, which is a limitation
    // a user must know when asking for a mux
    function automatic gate_cfg_pkg::cell_pins_t encode(input gate_cfg_pkg::cell_cmd_t c);
        gate_cfg_pkg::cell_pins_t p;
        p = '0;
        p.oe_low = ~c.enable;
        case (c.func)
            `FN_BUFFER:
            begin
                p.in_a = c.op1;
            end
            `FN_INVERT:
            begin
                p.in_a = c.op1;
                p.in_invert = 1'b1;
            end
            `FN_MUX:
            begin
                p.in_a = c.op1;
                p.in_b = c.op2;
                p.in_sel = c.op2 ^ c.op1 ? c.op2 : c.op1;
            end
            `FN_MUX_INV:
            begin
                p.in_a = c.op1;
                p.in_b = c.op2;
                p.in_sel = c.op2;
                p.in_invert = 1'b1;
            end
            `FN_AND:
            begin
                p.in_b = c.op1;
                p.in_sel = c.op2;
            end
            `FN_NAND:
            begin
                p.in_b = c.op1;
                p.in_sel = c.op2;
                p.in_invert = 1'b1;
            end
            `FN_XOR:
            begin
                p.in_a = c.op1;
                p.in_invert = c.op2;
            end
            default:
            begin
                p.in_a = 1'b1;
                p.in_sel = c.op1;
                p.in_invert = c.op2;
            end
        endcase
        return p;
    endfunction

    // Reference of the cell function: select, then conditional invert
    function automatic logic model(input gate_cfg_pkg::cell_pins_t p);
        return (p.in_sel ? p.in_b : p.in_a) ^ p.in_invert;
    endfunction

    // ****************************************
    // Pin drive and result sampling
    // ****************************************
    // Two-flop synchroniser for the returned gate outputs
    logic [CELLS-1:0] sync1_reg;
    logic [CELLS-1:0] sync2_reg;

    // Pins are only levels; nothing is stored beyond the registered drive
    // Registering the ties keeps glitches of the request decode off the pins
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            for (int i = 0; i < CELLS; i++)
            begin
                pins_out[i] <= `PINS_OFF; // Disabled, all ties low
            end
        end
        else
        begin
            for (int i = 0; i < CELLS; i++)
            begin
                pins_out[i] <= encode(cmd_in[i]);
            end
        end
    end

    // The gate outputs change with no regard to this clock, so two flops come
    // before anything reads them; the cost is two clocks of latency
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end
        else
        begin
            sync1_reg <= gate_out_in;
            sync2_reg <= sync1_reg;
        end
    end

    // Registered once more so the output comes straight from a flop
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            result_out <= '0;
        end
        else
        begin
            result_out <= sync2_reg;
        end
    end

    // ****************************************
    // Expected cell output
    // ****************************************
    // Worked out from the registered ties, so it trails the pins by one clock;
    // compare it with result_out only once the pins have settled
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            expect_out <= '0;
        end
        else
        begin
            for (int i = 0; i < CELLS; i++)
            begin
                expect_out[i] <= model(pins_out[i]);
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    for (genvar g = 0; g < CELLS; g++)
    begin : chk
        // Function given by each tie pattern but the plain mux, and enable polarity, one clock after the request
        buf_tie_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
            (cmd_in[g].func == `FN_BUFFER) |=> (model(pins_out[g]) == $past(cmd_in[g].op1)))
            else $error("buffer tie wrong");
        inv_tie_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
            (cmd_in[g].func == `FN_INVERT) |=> (model(pins_out[g]) == !$past(cmd_in[g].op1)))
            else $error("inverter tie wrong");
        and_tie_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
            (cmd_in[g].func == `FN_AND) |=> (model(pins_out[g]) == $past(cmd_in[g].op1 & cmd_in[g].op2)))
            else $error("and tie wrong");
        nand_tie_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
            (cmd_in[g].func == `FN_NAND) |=> (model(pins_out[g]) == !$past(cmd_in[g].op1 & cmd_in[g].op2)))
            else $error("nand tie wrong");
        xor_tie_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
            (cmd_in[g].func == `FN_XOR) |=> (model(pins_out[g]) == $past(cmd_in[g].op1 ^ cmd_in[g].op2)))
            else $error("xor tie wrong");
        xnor_tie_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
            (cmd_in[g].func == `FN_XNOR) |=> (model(pins_out[g]) == !$past(cmd_in[g].op1 ^ cmd_in[g].op2)))
            else $error("xnor tie wrong");
        mux_tie_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
            (cmd_in[g].func == `FN_MUX_INV) |=> (model(pins_out[g]) == !$past(cmd_in[g].op2 ? cmd_in[g].op2 : cmd_in[g].op1)))
            else $error("inverted mux tie wrong");
        enable_pol_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
            1'b1 |=> (pins_out[g].oe_low == !$past(cmd_in[g].enable)))
            else $error("enable polarity wrong");

        // Tie levels themselves, plus the function of the plain mux
        mux_func_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
            (cmd_in[g].func == `FN_MUX) |=> (model(pins_out[g]) == $past(cmd_in[g].op2 ? cmd_in[g].op2 : cmd_in[g].op1)))
            else $error("mux tie wrong");
        mux_level_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
            (cmd_in[g].func == `FN_MUX) |=> (pins_out[g].in_a == $past(cmd_in[g].op1)
                && pins_out[g].in_b == $past(cmd_in[g].op2) && !pins_out[g].in_invert))
            else $error("mux ties wrong");
        buf_level_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
            (cmd_in[g].func == `FN_BUFFER) |=> (!pins_out[g].in_sel && !pins_out[g].in_invert))
            else $error("buffer ties wrong");
        inv_level_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
            (cmd_in[g].func == `FN_INVERT) |=> (!pins_out[g].in_sel && pins_out[g].in_invert))
            else $error("inverter ties wrong");
        and_level_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
            (cmd_in[g].func == `FN_AND) |=> (!pins_out[g].in_a && !pins_out[g].in_invert))
            else $error("and ties wrong");
        nand_level_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
            (cmd_in[g].func == `FN_NAND) |=> (!pins_out[g].in_a && pins_out[g].in_invert))
            else $error("nand ties wrong");
        xor_level_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
            (cmd_in[g].func == `FN_XOR) |=> (!pins_out[g].in_sel))
            else $error("xor ties wrong");
        xnor_level_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
            (cmd_in[g].func == `FN_XNOR) |=> (pins_out[g].in_a && !pins_out[g].in_b))
            else $error("xnor ties wrong");
        ties_hold_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
            ($past(rst_n_in) && $stable(cmd_in[g])) |=> $stable(pins_out[g]))
            else $error("ties changed without request");
    end

endmodule
`default_nettype wire

// file: sim/gate_dev_model.sv
// Model of the triple configurable gate at the host's far side.
// Assumes a pull-up on each output, so a floating cell reads high.
`timescale 1ns/1ps
`default_nettype none
module gate_dev_model (
    input wire gate_cfg_pkg::cell_pins_t pins_in [3],
    output logic [2:0] gate_out_out
);
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            if (pins_in[i].oe_low)
                gate_out_out[i] = 1'b1;
            else
                gate_out_out[i] = (pins_in[i].in_sel ? pins_in[i].in_b : pins_in[i].in_a) ^ pins_in[i].in_invert;
        end
    end
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// Random and corner tests of the gate host against the device model.
// Assumes 4 clocks from request to settled result.
`timescale 1ns/1ps
`default_nettype none
`include "gate_cfg_map.svh"
`define CHK(nm, e, s) begin n_checks++; if ((e) !== (s)) begin n_mismatch++; $display("BAD %s %b %b", nm, e, s); end end
module tb_top;
    logic core_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    gate_cfg_pkg::cell_cmd_t cmd [3] = '{default: '0};
    gate_cfg_pkg::cell_pins_t pins [3];
    logic [2:0] g_out, res, exp_v;
    int n_mismatch = 0;
    int n_checks = 0;
    logic [31:0] seed = 32'h95AA;
    always #10 core_clk_in = ~core_clk_in;
    gate_cfg_host i_dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .cmd_in(cmd), .gate_out_in(g_out),
        .pins_out(pins), .result_out(res), .expect_out(exp_v));
    gate_dev_model i_dev (.pins_in(pins), .gate_out_out(g_out));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Known result of a request; the mux codes steer the select from op2
    function automatic logic cmd_fn(input gate_cfg_pkg::cell_cmd_t c);
        case (c.func)
            `FN_BUFFER: return c.op1;
            `FN_INVERT: return ~c.op1;
            `FN_AND: return c.op1 & c.op2;
            `FN_NAND: return ~(c.op1 & c.op2);
            `FN_XOR: return c.op1 ^ c.op2;
            `FN_XNOR: return ~(c.op1 ^ c.op2);
            `FN_MUX: return c.op2 ? c.op2 : c.op1;
            default: return ~(c.op2 ? c.op2 : c.op1);
        endcase
    endfunction
    task automatic settle_check();
        logic k;
        logic y;
        repeat (6) @(negedge core_clk_in);
        for (int i = 0; i < 3; i++)
        begin
            k = cmd_fn(cmd[i]);
            y = (pins[i].in_sel ? pins[i].in_b : pins[i].in_a) ^ pins[i].in_invert;
            if (cmd[i].enable !== 1'b1)
            begin
                `CHK("oe", 1'b1, pins[i].oe_low)
                `CHK("float", 1'b1, res[i])
            end
            else
            begin
                `CHK("oe", 1'b0, pins[i].oe_low)
                `CHK("res", k, res[i])
                `CHK("exp", k, exp_v[i])
                `CHK("func", k, y)
            end
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(negedge core_clk_in);
        rst_n_in = 1'b1;
        // Every code and operand pair on cell 0, the same disabled on cell 1, cell 2 random
        for (int n = 0; n < 32; n++)
        begin
            seed = lfsr(seed);
            cmd[0] = {1'b1, n[4:0]};
            cmd[1] = {1'b0, n[4:0]};
            cmd[2] = seed[5:0];
            settle_check();
        end
        $display("corner test done");
        for (int n = 0; n < 60; n++)
        begin
            for (int i = 0; i < 3; i++)
            begin
                seed = lfsr(seed);
                cmd[i] = seed[5:0];
            end
            settle_check();
        end
        $display("random test done");
        rst_n_in = 1'b0;
        #1;
        for (int i = 0; i < 3; i++)
            `CHK("rst_oe", 1'b1, pins[i].oe_low)
        `CHK("rst_res", 3'h0, res)
        `CHK("rst_exp", 3'h0, exp_v)
        // Release again mid-run with requests already standing
        repeat (2) @(negedge core_clk_in);
        rst_n_in = 1'b1;
        for (int n = 0; n < 8; n++)
        begin
            for (int i = 0; i < 3; i++)
            begin
                seed = lfsr(seed);
                cmd[i] = seed[5:0];
            end
            settle_check();
        end
        $display("reset test done");
        test_done();
    end
endmodule
`default_nettype wire
